// ---- pkg/ebp_regs.svh ----
// Register offsets, field positions, reset values and address map of the bus sequencer.
`ifndef EBP_REGS_SVH
`define EBP_REGS_SVH
`define EBP_REG_CTRL   4'h0
`define EBP_REG_STAT   4'h4
`define EBP_CTRL_RST   8'h00
`define EBP_ASW_LSB    0
`define EBP_AHW_LSB    4
`define EBP_AREA_LSB   24
`define EBP_EXT_BASE   32'h0010_0000
`define EBP_RAM_BASE   32'h03FF_0000
`define EBP_PERI_BASE  32'h03FF_F000
`endif

// ---- pkg/ebp_pkg.sv ----
// Types shared by the bus sequencer and its operand splitter.
package ebp_pkg;
	typedef enum logic [1:0] {EBP_BYTE, EBP_HALF, EBP_WORD} ebp_size_t;
	typedef enum logic [2:0] {ST_IDLE, ST_T1H, ST_ASW, ST_T1L, ST_AHW, ST_T2, ST_HOLD} ebp_state_t;
	typedef enum logic [1:0] {SRC_OP, SRC_BR, SRC_SQ} ebp_src_t;
endpackage

// ---- pkg/ebp_split_if.sv ----
// Interface between the sequencer and the misaligned operand splitter.
`timescale 1ns/100ps
`default_nettype none
interface ebp_split_if import ebp_pkg::*; ();
	logic      [1:0] addr_lo;
	ebp_size_t       size;
	logic      [1:0] idx;
	logic      [1:0] count;
	logic      [1:0] offset;
	ebp_size_t       width;
	logic      [1:0] lanes;
	modport split (input addr_lo, input size, input idx,
		output count, output offset, output width, output lanes);
	modport user (output addr_lo, output size, output idx,
		input count, input offset, input width, input lanes);
endinterface
`default_nettype wire

// ---- logic/ebp_splitter.sv ----
// Splits one operand into ordered byte and halfword bus cycles on a 16-bit bus.
`timescale 1ns/100ps
`default_nettype none
module ebp_splitter import ebp_pkg::*; (
	ebp_split_if.split sif
);
	logic sub_lsb;

	always_comb begin
		sif.count  = 2'h1;
		sif.offset = 2'h0;
		sif.width  = sif.size;
		case (sif.size)
			EBP_HALF: begin
				if (sif.addr_lo[0]) begin
					sif.count  = 2'h2;
					sif.width  = EBP_BYTE;
					sif.offset = {1'b0, sif.idx[0]};
				end
			end
			EBP_WORD: begin
				if (sif.addr_lo[0]) begin
					sif.count = 2'h3;
					case (sif.idx)
						2'h0: begin
							sif.width  = EBP_BYTE;
							sif.offset = 2'h0;
						end
						2'h1: begin
							sif.width  = EBP_HALF;
							sif.offset = 2'h1;
						end
						default: begin
							sif.width  = EBP_BYTE;
							sif.offset = 2'h3;
						end
					endcase
				end else begin
					sif.count  = 2'h2;
					sif.width  = EBP_HALF;
					sif.offset = {sif.idx[0], 1'b0};
				end
			end
			default: begin
			end
		endcase
	end

	// An odd sub-address puts a byte on the upper lane.
	assign sub_lsb = sif.addr_lo[0] ^ sif.offset[0];

	always_comb begin
		if (sif.width == EBP_BYTE) begin
			sif.lanes = sub_lsb ? 2'h2 : 2'h1;
		end else begin
			sif.lanes = 2'h3;
		end
	end
endmodule
`default_nettype wire

// ---- logic/ebp_top.sv ----
// External bus priority sequencer with misaligned operand splitting and address waits.
// Behaviour
// - Grant order is bus hold, operand access, branch fetch, then successive fetch.
// - An instruction fetch may slip between the read and write of read-modify-write.
// - No fetch or bus hold is let in between sub-cycles of one operand.
// - Halfword and word operands are accepted at any byte address.
// - An odd halfword goes out as two byte cycles.
// - An odd word goes out as byte, halfword, byte, in that order.
// - A word at address ending 10 goes out as two halfword cycles.
// - No successive prefetch is issued into the peripheral register space.
// - Successive fetch never runs from internal ROM into external memory.
// - An enabled setup wait stretches the high phase of the first state by one clock.
// - An enabled hold wait stretches the low phase of the first state by one clock.
`timescale 1ns/100ps
`default_nettype none
`include "ebp_regs.svh"
module ebp_top import ebp_pkg::*; (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        ce,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        bus_hold_request_n,
	output logic             bus_hold_ack_n,
	input  wire logic        op_req,
	input  wire logic [31:0] op_addr,
	input  wire ebp_size_t   op_size,
	input  wire logic        op_write,
	input  wire logic        op_rmw_rd,
	input  wire logic [31:0] op_wdata,
	output logic             op_done,
	output logic      [31:0] op_rdata,
	input  wire logic        br_req,
	input  wire logic [31:0] br_addr,
	output logic             br_done,
	input  wire logic        sq_req,
	input  wire logic [31:0] sq_addr,
	output logic             sq_done,
	output logic             sq_refused,
	output logic      [31:0] bus_addr,
	output logic      [1:0]  bus_lanes,
	output logic             bus_write,
	output logic      [15:0] bus_wdata,
	input  wire logic [15:0] bus_rdata,
	output logic             bus_ale,
	output logic             bus_strobe,
	output logic             bus_active
);
	// ************************************************************
	// Registers and combinational next values
	// ************************************************************
	ebp_state_t  state_ff, nxt_state;
	ebp_src_t    src_ff, nxt_src;
	ebp_size_t   size_ff, nxt_size;
	logic [31:0] base_ff, nxt_base;
	logic [31:0] wdata_ff, nxt_wdata;
	logic        wr_ff, nxt_wr;
	logic [1:0]  idx_ff, nxt_idx;
	logic [1:0]  cur_off_ff;
	logic        cur_byte_ff, cur_lsb_ff;
	logic [7:0]  ctrl_ff;
	logic        rmw_pend_ff, last_rom_ff;
	logic        hreq_s1_ff, hreq_s2_ff;
	logic        start, finish, refuse, hold_req, sq_bad, fetch_ok, settle;
	logic [3:0]  asw_vec, ahw_vec;
	logic [1:0]  area;
	logic [31:0] seg;
	logic [1:0]  strobe_cnt_ff;
	ebp_split_if sif ();

	ebp_splitter u_split (
		.sif (sif.split)
	);

	assign sif.addr_lo = nxt_base[1:0];
	assign sif.size    = nxt_size;
	assign sif.idx     = nxt_idx;

	// The hold request comes from another master and is synchronised first.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			hreq_s1_ff <= 1'b0;
			hreq_s2_ff <= 1'b0;
		end else if (ce) begin
			hreq_s1_ff <= ~bus_hold_request_n;
			hreq_s2_ff <= hreq_s1_ff;
		end
	end

	assign hold_req = hreq_s2_ff;
	assign area     = bus_addr[`EBP_AREA_LSB +: 2];
	assign asw_vec  = ctrl_ff[`EBP_ASW_LSB +: 4];
	assign ahw_vec  = ctrl_ff[`EBP_AHW_LSB +: 4];
	assign sq_bad   = (sq_addr >= `EBP_PERI_BASE)
		|| (last_rom_ff && sq_addr >= `EBP_EXT_BASE && sq_addr < `EBP_RAM_BASE);
	assign fetch_ok = br_req || (sq_req && !sq_bad);
	// A requester drops its level only after it has seen its pulse, so no request is taken then.
	assign settle   = op_done || br_done || sq_done || sq_refused;

	// ************************************************************
	// Arbitration and bus cycle sequencing
	// ************************************************************
	always_comb begin
		nxt_state = state_ff;
		nxt_src   = src_ff;
		nxt_size  = size_ff;
		nxt_base  = base_ff;
		nxt_wdata = wdata_ff;
		nxt_wr    = wr_ff;
		nxt_idx   = idx_ff;
		start     = 1'b0;
		finish    = 1'b0;
		refuse    = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				if (hold_req) begin
					nxt_state = ST_HOLD;
				end else if (settle) begin
					nxt_state = ST_IDLE;
				end else if (op_req && !(rmw_pend_ff && fetch_ok)) begin
					nxt_src   = SRC_OP;
					nxt_base  = op_addr;
					nxt_size  = op_size;
					nxt_wr    = op_write;
					nxt_wdata = op_wdata;
					start     = 1'b1;
				end else if (br_req) begin
					nxt_src  = SRC_BR;
					nxt_base = br_addr;
					nxt_size = EBP_HALF;
					nxt_wr   = 1'b0;
					start    = 1'b1;
				end else if (sq_req) begin
					if (sq_bad) begin
						refuse = 1'b1;
					end else begin
						nxt_src  = SRC_SQ;
						nxt_base = sq_addr;
						nxt_size = EBP_HALF;
						nxt_wr   = 1'b0;
						start    = 1'b1;
					end
				end
				if (start) begin
					nxt_idx   = 2'h0;
					nxt_state = ST_T1H;
				end
			end
			ST_T1H: begin
				nxt_state = asw_vec[area] ? ST_ASW : ST_T1L;
			end
			ST_ASW: begin
				nxt_state = ST_T1L;
			end
			ST_T1L: begin
				nxt_state = ahw_vec[area] ? ST_AHW : ST_T2;
			end
			ST_AHW: begin
				nxt_state = ST_T2;
			end
			ST_T2: begin
				if (idx_ff == 2'(sif.count - 2'h1)) begin
					finish    = 1'b1;
					nxt_state = ST_IDLE;
				end else begin
					nxt_idx   = 2'(idx_ff + 2'h1);
					start     = 1'b1;
					nxt_state = ST_T1H;
				end
			end
			ST_HOLD: begin
				if (!hold_req) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_ff <= ST_IDLE;
			src_ff   <= SRC_OP;
			size_ff  <= EBP_BYTE;
			base_ff  <= 32'h0000_0000;
			wdata_ff <= 32'h0000_0000;
			wr_ff    <= 1'b0;
			idx_ff   <= 2'h0;
		end else if (ce) begin
			state_ff <= nxt_state;
			src_ff   <= nxt_src;
			size_ff  <= nxt_size;
			base_ff  <= nxt_base;
			wdata_ff <= nxt_wdata;
			wr_ff    <= nxt_wr;
			idx_ff   <= nxt_idx;
		end
	end

	// ************************************************************
	// External bus outputs
	// ************************************************************
	assign seg = nxt_wdata >> {sif.offset, 3'h0};

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			bus_addr    <= 32'h0000_0000;
			bus_lanes   <= 2'h0;
			bus_write   <= 1'b0;
			bus_wdata   <= 16'h0000;
			cur_off_ff  <= 2'h0;
			cur_byte_ff <= 1'b0;
			cur_lsb_ff  <= 1'b0;
		end else if (ce && start) begin
			bus_addr    <= nxt_base + {30'h0, sif.offset};
			bus_lanes   <= sif.lanes;
			bus_write   <= nxt_wr;
			bus_wdata   <= (sif.width == EBP_BYTE && sif.lanes == 2'h2) ?
				{seg[7:0], 8'h00} : seg[15:0];
			cur_off_ff  <= sif.offset;
			cur_byte_ff <= (sif.width == EBP_BYTE);
			cur_lsb_ff  <= (sif.lanes == 2'h2);
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			bus_ale        <= 1'b0;
			bus_strobe     <= 1'b0;
			bus_active     <= 1'b0;
			bus_hold_ack_n <= 1'b1;
		end else if (ce) begin
			bus_ale        <= (nxt_state == ST_T1H) || (nxt_state == ST_ASW);
			bus_strobe     <= (nxt_state == ST_T2);
			bus_active     <= (nxt_state != ST_IDLE) && (nxt_state != ST_HOLD);
			bus_hold_ack_n <= (nxt_state != ST_HOLD);
		end
	end

	// Read bytes are placed by operand offset so the CPU sees one assembled word.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			op_rdata <= 32'h0000_0000;
		end else if (ce && state_ff == ST_T2 && src_ff == SRC_OP && !wr_ff) begin
			if (cur_byte_ff) begin
				op_rdata[{cur_off_ff, 3'h0} +: 8] <= cur_lsb_ff ? bus_rdata[15:8] : bus_rdata[7:0];
			end else begin
				op_rdata[{cur_off_ff, 3'h0} +: 16] <= bus_rdata;
			end
		end
	end

	// ************************************************************
	// Completion pulses and fetch history
	// ************************************************************
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			op_done    <= 1'b0;
			br_done    <= 1'b0;
			sq_done    <= 1'b0;
			sq_refused <= 1'b0;
		end else if (ce) begin
			op_done    <= finish && src_ff == SRC_OP;
			br_done    <= finish && src_ff == SRC_BR;
			sq_done    <= finish && src_ff == SRC_SQ;
			sq_refused <= refuse;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rmw_pend_ff <= 1'b0;
			last_rom_ff <= 1'b0;
		end else if (ce) begin
			if (finish && src_ff == SRC_OP && op_rmw_rd) begin
				rmw_pend_ff <= 1'b1;
			end else if (start && state_ff == ST_IDLE) begin
				rmw_pend_ff <= 1'b0;
			end
			if (start && state_ff == ST_IDLE && nxt_src != SRC_OP) begin
				last_rom_ff <= (nxt_base < `EBP_EXT_BASE);
			end
		end
	end

	// ************************************************************
	// Avalon-MM slave
	// ************************************************************
	// The answer always takes two edges; data is loaded on the same edge that waitrequest falls.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
			ctrl_ff         <= `EBP_CTRL_RST;
		end else if (ce) begin
			if ((avs_read || avs_write) && avs_waitrequest) begin
				avs_waitrequest <= 1'b0;
				case (avs_address)
					`EBP_REG_CTRL: avs_readdata <= {24'h0, ctrl_ff};
					`EBP_REG_STAT: avs_readdata <= {27'h0, rmw_pend_ff, last_rom_ff,
						idx_ff != 2'h0, state_ff == ST_HOLD, state_ff != ST_IDLE};
					default:       avs_readdata <= 32'h0000_0000;
				endcase
			end else begin
				avs_waitrequest <= 1'b1;
				if (avs_write && !avs_waitrequest && avs_address == `EBP_REG_CTRL
					&& avs_byteenable[0]) begin
					ctrl_ff <= avs_writedata[7:0];
				end
			end
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			strobe_cnt_ff <= 2'h0;
		end else if (ce) begin
			if (start && state_ff == ST_IDLE) begin
				strobe_cnt_ff <= 2'h0;
			end else if (state_ff == ST_T2) begin
				strobe_cnt_ff <= 2'(strobe_cnt_ff + 2'h1);
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_hold_first;
		state_ff == ST_IDLE && hold_req && ce |=> state_ff == ST_HOLD && !bus_hold_ack_n;
	endproperty
	a_hold_first: assert property (p_hold_first) else $error("hold not granted first");

	property p_op_over_fetch;
		state_ff == ST_IDLE && !hold_req && op_req && !rmw_pend_ff && !settle && ce
			|=> src_ff == SRC_OP && state_ff == ST_T1H;
	endproperty
	a_op_over_fetch: assert property (p_op_over_fetch) else $error("operand lost priority");

	property p_rmw_fetch;
		state_ff == ST_IDLE && !hold_req && rmw_pend_ff && br_req && !settle && ce
			|=> src_ff == SRC_BR;
	endproperty
	a_rmw_fetch: assert property (p_rmw_fetch) else $error("fetch not let into rmw gap");

	property p_locked;
		state_ff == ST_T2 && !finish && ce |=> state_ff == ST_T1H && bus_hold_ack_n;
	endproperty
	a_locked: assert property (p_locked) else $error("operand group broken");

	property p_half_odd;
		op_done && size_ff == EBP_HALF && base_ff[0] |-> strobe_cnt_ff == 2'h2;
	endproperty
	a_half_odd: assert property (p_half_odd) else $error("odd halfword not two cycles");

	property p_word_odd;
		op_done && size_ff == EBP_WORD && base_ff[0] |-> strobe_cnt_ff == 2'h3;
	endproperty
	a_word_odd: assert property (p_word_odd) else $error("odd word not three cycles");

	property p_word_mid;
		bus_strobe && src_ff == SRC_OP && size_ff == EBP_WORD && base_ff[0] && idx_ff == 2'h1
			|-> bus_lanes == 2'h3 && bus_addr == base_ff + 32'h1;
	endproperty
	a_word_mid: assert property (p_word_mid) else $error("odd word middle cycle wrong");

	property p_word_two;
		op_done && size_ff == EBP_WORD && base_ff[1:0] == 2'h2 |-> strobe_cnt_ff == 2'h2;
	endproperty
	a_word_two: assert property (p_word_two) else $error("word at 10 not two cycles");

	property p_no_peri_prefetch;
		state_ff == ST_IDLE && !hold_req && !op_req && !br_req && sq_req
			&& sq_addr >= `EBP_PERI_BASE && !settle && ce |=> sq_refused && state_ff == ST_IDLE;
	endproperty
	a_no_peri_prefetch: assert property (p_no_peri_prefetch) else $error("prefetch into peri");

	property p_setup_wait;
		state_ff == ST_T1H && asw_vec[area] && ce |=> state_ff == ST_ASW && bus_ale;
	endproperty
	a_setup_wait: assert property (p_setup_wait) else $error("setup wait missing");

	property p_hold_wait;
		state_ff == ST_T1L && ahw_vec[area] && ce |=> state_ff == ST_AHW && !bus_strobe;
	endproperty
	a_hold_wait: assert property (p_hold_wait) else $error("hold wait missing");
endmodule
`default_nettype wire

// ---- testbench/ebp_mem_model.sv ----
// Behavioural external memory that answers the sixteen-bit bus of the sequencer.
`timescale 1ns/100ps
`default_nettype none
module ebp_mem_model (
	input  wire logic        clk,
	input  wire logic [31:0] bus_addr,
	input  wire logic [1:0]  bus_lanes,
	input  wire logic        bus_write,
	input  wire logic [15:0] bus_wdata,
	input  wire logic        bus_strobe,
	output logic      [15:0] bus_rdata
);
	// ****************************************
	// Storage and read path
	// ****************************************
	logic [7:0]  mem [logic [31:0]];
	logic [15:0] last_q = 16'h0000;
	function automatic logic [7:0] rd(input logic [31:0] a);
		return mem.exists(a) ? mem[a] : a[7:0] ^ 8'h5A;
	endfunction
	// Outside T2 the lines toggle, so a sequencer that samples late never sees stale data.
	assign bus_rdata = (bus_strobe && !bus_write) ?
		{rd({bus_addr[31:1], 1'b1}), rd({bus_addr[31:1], 1'b0})} : ~last_q;
	always @(posedge clk) begin
		last_q <= bus_rdata;
		if (bus_strobe && bus_write && bus_lanes[0]) begin
			mem[{bus_addr[31:1], 1'b0}] = bus_wdata[7:0];
		end
		if (bus_strobe && bus_write && bus_lanes[1]) begin
			mem[{bus_addr[31:1], 1'b1}] = bus_wdata[15:8];
		end
	end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking testbench of the external bus priority sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "ebp_regs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_top import ebp_pkg::*;;
	// ****************************************
	// Signals, design and memory
	// ****************************************
	logic        clk, reset_n, ce, avs_read, avs_write, avs_waitrequest;
	logic [3:0]  avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, op_addr, op_wdata, op_rdata;
	logic [31:0] br_addr, sq_addr, bus_addr;
	logic        bus_hold_request_n, bus_hold_ack_n, op_req, op_write, op_rmw_rd, op_done;
	logic        br_req, br_done, sq_req, sq_done, sq_refused;
	logic        bus_write, bus_ale, bus_strobe, bus_active;
	ebp_size_t   op_size;
	logic [1:0]  bus_lanes;
	logic [15:0] bus_wdata, bus_rdata;
	logic [33:0] log_q[$];
	int          errors = 0;
	int          checks = 0;
	ebp_top uut (.clk, .reset_n, .ce, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .bus_hold_request_n,
		.bus_hold_ack_n, .op_req, .op_addr, .op_size, .op_write, .op_rmw_rd, .op_wdata,
		.op_done, .op_rdata, .br_req, .br_addr, .br_done, .sq_req, .sq_addr, .sq_done,
		.sq_refused, .bus_addr, .bus_lanes, .bus_write, .bus_wdata, .bus_rdata, .bus_ale,
		.bus_strobe, .bus_active);
	ebp_mem_model mem_u (.clk, .bus_addr, .bus_lanes, .bus_write, .bus_wdata, .bus_strobe,
		.bus_rdata);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (bus_strobe === 1'b1) begin
			log_q.push_back({bus_lanes, bus_addr});
		end
	end
	// ****************************************
	// Bus tasks
	// ****************************************
	function automatic logic [7:0] pat(input logic [31:0] a);
		return a[7:0] ^ 8'h5A;
	endfunction
	task automatic complete_run();
		if (errors == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic av_xfer(input logic w, input logic [3:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= w;
		avs_read <= !w;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
	task automatic op_run(input logic [31:0] a, input ebp_size_t s, input logic w,
		input logic [31:0] wd, output logic [31:0] rd, output int n);
		n = 0;
		op_addr <= a;
		op_size <= s;
		op_write <= w;
		op_wdata <= wd;
		op_req <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (op_done !== 1'b1);
		rd = op_rdata;
		op_req <= 1'b0;
		@(posedge clk);
	endtask
	task automatic fetch(input logic sq, input logic [31:0] a, output logic refused);
		if (sq) begin
			sq_addr <= a;
			sq_req <= 1'b1;
		end else begin
			br_addr <= a;
			br_req <= 1'b1;
		end
		do @(posedge clk); while ((sq ? (sq_done | sq_refused) : br_done) !== 1'b1);
		refused = sq_refused;
		if (sq) sq_req <= 1'b0;
		else br_req <= 1'b0;
		@(posedge clk);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic split_case(input logic [31:0] a, input ebp_size_t s, input logic w,
		input logic [31:0] wd);
		logic [31:0] ea[$];
		logic [31:0] d, e, nx;
		int n, nb;
		nb = (s == EBP_WORD) ? 4 : (s == EBP_HALF) ? 2 : 1;
		ea = {a};
		if (a[0] && nb == 2) ea = {a, a + 32'h1};
		if (a[0] && nb == 4) ea = {a, a + 32'h1, a + 32'h3};
		if (!a[0] && nb == 4) ea = {a, a + 32'h2};
		log_q = {};
		op_run(a, s, w, wd, d, n);
		`CHK("sub_count", ea.size(), log_q.size())
		foreach (ea[i]) begin
			nx = (i + 1 < ea.size()) ? ea[i + 1] : a + nb;
			e = (nx - ea[i] == 2) ? 3 : (ea[i][0] ? 2 : 1);
			`CHK("sub_addr", ea[i], log_q[i][31:0])
			`CHK("sub_lanes", e[1:0], log_q[i][33:32])
		end
		e = 32'h0;
		for (int k = 0; k < nb; k++) e[8 * k +: 8] = pat(a + k);
		if (!w) `CHK("op_rdata", e, d)
	endtask
	task automatic wait_test();
		logic [31:0] d;
		int n0, n1, n2, n3;
		op_run(32'h0010_0010, EBP_HALF, 1'b0, 32'h0, d, n0);
		av_xfer(1'b1, 4'h2 - 4'h2, 32'h0000_0002, d);
		op_run(32'h0010_0010, EBP_HALF, 1'b0, 32'h0, d, n3);
		av_xfer(1'b1, 4'h0, 32'h0000_0001, d);
		op_run(32'h0010_0010, EBP_HALF, 1'b0, 32'h0, d, n1);
		av_xfer(1'b1, 4'h0, 32'h0000_0011, d);
		op_run(32'h0010_0010, EBP_HALF, 1'b0, 32'h0, d, n2);
		av_xfer(1'b1, 4'h0, 32'h0, d);
		`CHK("other_area", n0, n3)
		`CHK("setup_wait", n0 + 1, n1)
		`CHK("hold_wait", n0 + 2, n2)
	endtask
	task automatic hold_test();
		logic [31:0] d;
		int n;
		bus_hold_request_n <= 1'b0;
		repeat (8) @(posedge clk);
		`CHK("hold_ack", 1'b0, bus_hold_ack_n)
		fork
			op_run(32'h0010_0020, EBP_BYTE, 1'b0, 32'h0, d, n);
			begin
				repeat (6) @(posedge clk);
				`CHK("held_bus", 1'b0, bus_active)
				bus_hold_request_n <= 1'b1;
			end
		join
		`CHK("hold_end", 1'b1, bus_hold_ack_n)
	endtask
	task automatic group_test();
		logic [31:0] d;
		int n;
		logic bad;
		bad = 1'b0;
		fork
			op_run(32'h0010_0031, EBP_WORD, 1'b0, 32'h0, d, n);
			begin
				@(posedge clk);
				bus_hold_request_n <= 1'b0;
				do begin
					@(posedge clk);
					if (bus_hold_ack_n !== 1'b1) bad = 1'b1;
				end while (op_done !== 1'b1);
			end
		join
		`CHK("no_hold_in_group", 1'b0, bad)
		repeat (6) @(posedge clk);
		`CHK("hold_after_group", 1'b0, bus_hold_ack_n)
		bus_hold_request_n <= 1'b1;
		repeat (6) @(posedge clk);
	endtask
	task automatic prio_test();
		logic [31:0] d;
		logic r;
		int n;
		log_q = {};
		fork
			op_run(32'h0010_0090, EBP_HALF, 1'b0, 32'h0, d, n);
			fetch(1'b0, 32'h0010_0200, r);
			fetch(1'b1, 32'h0010_0300, r);
		join
		`CHK("first", 32'h0010_0090, log_q[0][31:0])
		`CHK("second", 32'h0010_0200, log_q[1][31:0])
		`CHK("third", 32'h0010_0300, log_q[2][31:0])
	endtask
	task automatic rmw_test();
		logic [31:0] d;
		logic r;
		int n;
		op_rmw_rd <= 1'b1;
		op_run(32'h0010_00A0, EBP_HALF, 1'b0, 32'h0, d, n);
		op_rmw_rd <= 1'b0;
		log_q = {};
		fork
			op_run(32'h0010_00A0, EBP_HALF, 1'b1, 32'h0000_1234, d, n);
			fetch(1'b0, 32'h0010_0400, r);
		join
		`CHK("rmw_gap", 32'h0010_0400, log_q[0][31:0])
		`CHK("rmw_write", 32'h0010_00A0, log_q[1][31:0])
	endtask
	task automatic refuse_test();
		logic r;
		fetch(1'b0, 32'h0000_1000, r);
		log_q = {};
		fetch(1'b1, `EBP_EXT_BASE, r);
		`CHK("rom_to_ext", 1'b1, r)
		fetch(1'b1, `EBP_PERI_BASE, r);
		`CHK("into_peri", 1'b1, r)
		`CHK("no_cycle", 0, log_q.size())
		fetch(1'b1, 32'h0000_1002, r);
		`CHK("rom_seq", 1'b0, r)
	endtask
	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		complete_run();
	end
	initial begin
		logic [31:0] d;
		int n;
		{reset_n, avs_read, avs_write, op_req, op_write, op_rmw_rd, br_req, sq_req} = 8'h00;
		{ce, bus_hold_request_n} = 2'b11;
		{avs_address, avs_byteenable} = 8'h0F;
		{avs_writedata, op_addr, op_wdata, br_addr, sq_addr} = '0;
		op_size = EBP_BYTE;
		repeat (4) @(posedge clk);
		`CHK("rst_wait", 1'b1, avs_waitrequest)
		`CHK("rst_ack", 1'b1, bus_hold_ack_n)
		reset_n <= 1'b1;
		@(posedge clk);
		av_xfer(1'b0, 4'h0, 32'h0, d);
		`CHK("ctrl_rst", `EBP_CTRL_RST, d[7:0])
		av_xfer(1'b1, 4'h0, 32'h0000_00A5, d);
		av_xfer(1'b0, 4'h0, 32'h0, d);
		`CHK("ctrl", 8'hA5, d[7:0])
		av_xfer(1'b1, 4'h8, 32'hFFFF_FFFF, d);
		av_xfer(1'b0, 4'h8, 32'h0, d);
		`CHK("unmapped", 32'h0, d)
		av_xfer(1'b1, 4'h0, 32'h0, d);
		split_case(32'h0010_0041, EBP_HALF, 1'b0, 32'h0);
		split_case(32'h0010_0051, EBP_WORD, 1'b0, 32'h0);
		split_case(32'h0010_0062, EBP_WORD, 1'b0, 32'h0);
		split_case(32'h0010_0070, EBP_WORD, 1'b0, 32'h0);
		split_case(32'h0010_0081, EBP_WORD, 1'b1, 32'h8877_6655);
		op_run(32'h0010_0081, EBP_WORD, 1'b0, 32'h0, d, n);
		`CHK("readback", 32'h8877_6655, d)
		wait_test();
		hold_test();
		group_test();
		prio_test();
		rmw_test();
		refuse_test();
		complete_run();
	end
endmodule
`default_nettype wire
